// File: logic/rsc_params.svh
// Register map, field positions, reset values and counts of reset control
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH

// ====================================================================
// Register byte offsets
`define RSC_CAUSE_OFS 5'h00
`define RSC_CTRL_OFS 5'h04
`define RSC_PSOFT_OFS 5'h08
`define RSC_ISTS_OFS 5'h0c
`define RSC_IMASK_OFS 5'h10
`define RSC_WDT_OFS 5'h14
`define RSC_STATE_OFS 5'h18

// ====================================================================
// Field positions and reset values
`define RSC_C_POR 0
`define RSC_C_EXT 1
`define RSC_C_BOR 2
`define RSC_C_SW 3
`define RSC_C_WDT 4
`define RSC_CAUSE_RST 5'h01
`define RSC_CTL_BOREN 0
`define RSC_CTL_SYSREQ 1
`define RSC_CTL_WDTEN 2
`define RSC_I_BOR 0
`define RSC_I_WDT 1

// ====================================================================
// Cycle counts
`define RSC_HOLD_CYC 4'h4
`define RSC_PRST_CYC 2'h3
`endif

// File: logic/rsc_periph_reset.sv
// Per-module software peripheral reset pulse generator
`timescale 1ns/1ps
`include "rsc_params.svh"
module rsc_periph_reset
  import rsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  rsc_req_if.prst rq
);
  typedef struct packed {
    rsc_pvec_t prev;
    logic [7:0][1:0] cnt;
    rsc_pvec_t active;
  } rsc_prst_s;
  rsc_prst_s st;
  rsc_prst_s next_st;

  // A falling select bit starts that module's own reset pulse
  always_comb
  begin
    next_st = st;
    next_st.prev = rq.psoft;
    for (int i = 0; i < 8; i++)
    begin
      if (st.prev[i] && !rq.psoft[i])
        next_st.cnt[i] = `RSC_PRST_CYC;
      else if (st.cnt[i] != 2'h0)
        next_st.cnt[i] = st.cnt[i] - 2'h1;
      next_st.active[i] = (next_st.cnt[i] != 2'h0);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign rq.pactive = st.active;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Every fallen bit pulses; no unselected module starts a pulse
  sel_pulse_a: assert property (
    (st.prev & ~rq.psoft) != 8'h0 |=>
    ((st.active & $past(st.prev) & ~$past(rq.psoft)) ==
     ($past(st.prev) & ~$past(rq.psoft))) &&
    ((st.active & ~$past(st.active) & ~($past(st.prev) &
      ~$past(rq.psoft))) == 8'h0))
    else $error("peripheral reset does not follow selection");
endmodule

// File: logic/rsc_pkg.sv
// Types shared by the reset control modules
package rsc_pkg;
  typedef logic [7:0] rsc_pvec_t;
  typedef enum logic [2:0]
  {
    BOOT_HOLD = 3'b000,
    BOOT_SP = 3'b001,
    BOOT_PC = 3'b010,
    BOOT_INSN = 3'b011,
    BOOT_RUN = 3'b100
  } rsc_boot_e;
endpackage

// File: logic/rsc_req_if.sv
// Links between the reset control and its helper units
`timescale 1ns/1ps
interface rsc_req_if;
  import rsc_pkg::*;
  rsc_pvec_t psoft;
  rsc_pvec_t pactive;
  logic wdt_to;
  logic wdt_clr;
  logic wdt_en;
  logic wdt_flag;
  logic wdt_rst;
  modport ctl (output psoft, wdt_to, wdt_clr, wdt_en,
               input pactive, wdt_flag, wdt_rst);
  modport prst (input psoft, output pactive);
  modport wdt (input wdt_to, wdt_clr, wdt_en, output wdt_flag, wdt_rst);
endinterface

// File: logic/rsc_reset_ctrl.sv
// Reset source merging, cause recording and boot fetch sequencing
//
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`include "rsc_params.svh"
module rsc_reset_ctrl
  import rsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic por_det_i,
  input wire logic rst_pin_n_i,
  input wire logic brownout_i,
  input wire logic wdt_timeout_i,
  input wire logic fetch_ack_i,
  input wire logic [2:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  output logic core_rst_n_o,
  output logic tap_rst_n_o,
  output logic pin_cfg_rst_n_o,
  output logic [7:0] periph_rst_n_o,
  output logic fetch_req_o,
  output logic [1:0] fetch_step_o,
  output logic core_run_o
);
  // ==================================================================
  // State
  typedef struct packed {
    logic wreq;
    logic [31:0] rdata;
    logic [4:0] cause;
    logic bor_en;
    logic wdt_en;
    rsc_pvec_t psoft;
    logic [1:0] ists;
    logic [1:0] imask;
    logic irq;
    logic por_done;
    logic [3:0] hold;
    logic core_rst;
    logic tap_rst;
    logic pcfg_rst;
    rsc_pvec_t prst;
    rsc_boot_e boot;
    logic freq;
    logic [1:0] fstep;
    logic run;
    logic bor_prev;
    logic wflag_prev;
  } rsc_top_s;

  // Power-on: every domain held, only the power-on cause left standing
  localparam rsc_top_s ST_RST = '{
    wreq: 1'b1, cause: `RSC_CAUSE_RST, core_rst: 1'b1,
    tap_rst: 1'b1, pcfg_rst: 1'b1, prst: 8'hff,
    boot: BOOT_HOLD, default: '0};

  rsc_top_s st;
  rsc_top_s next_st;
  logic [4:0] ofs;
  logic acc;
  logic wr;
  logic rd;
  logic sys_req;
  logic wdt_clr;
  logic por_live;
  logic pin_low;
  logic bor_rst;
  logic pulse_src;
  logic sys_rst;
  logic [4:0] cause_set;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;

  rsc_req_if rq ();

  // ==================================================================
  // Helper units
  rsc_periph_reset u_prst
  (
    .clk_i (clk_i),
    .rst_n_i (rst_n_i),
    .rq (rq.prst)
  );

  rsc_wdt_qual u_wdt
  (
    .clk_i (clk_i),
    .rst_n_i (rst_n_i),
    .rq (rq.wdt)
  );

  assign rq.psoft = st.psoft;
  assign rq.wdt_to = wdt_timeout_i;
  assign rq.wdt_clr = wdt_clr;
  assign rq.wdt_en = st.wdt_en;

  // ==================================================================
  // Register read decode
  function automatic logic [31:0] rsc_read(input logic [4:0] o);
    unique case (o)
      `RSC_CAUSE_OFS: rsc_read = {27'h0, st.cause};
      `RSC_CTRL_OFS: rsc_read = {29'h0, st.wdt_en, 1'b0, st.bor_en};
      `RSC_PSOFT_OFS: rsc_read = {24'h0, st.psoft};
      `RSC_ISTS_OFS: rsc_read = {30'h0, st.ists};
      `RSC_IMASK_OFS: rsc_read = {30'h0, st.imask};
      `RSC_WDT_OFS: rsc_read = {31'h0, rq.wdt_flag};
      `RSC_STATE_OFS: rsc_read = {25'h0, st.boot, st.tap_rst,
                                  st.pcfg_rst, st.por_done, st.core_rst};
      default: rsc_read = 32'h0;
    endcase
  endfunction

  // ==================================================================
  // Next state
  always_comb
  begin
    next_st = st;
    // Bus: one wait cycle, data captured early so it stands at the ack
    ofs = {avs_address_i, 2'b00};
    acc = (avs_read_i || avs_write_i) && !st.wreq;
    wr = acc && avs_write_i && avs_byteenable_i[0];
    rd = acc && avs_read_i;
    next_st.wreq = !((avs_read_i || avs_write_i) && st.wreq);
    if ((avs_read_i || avs_write_i) && st.wreq)
      next_st.rdata = rsc_read(ofs);

    // Software writes
    sys_req = wr && (ofs == `RSC_CTRL_OFS) &&
              avs_writedata_i[`RSC_CTL_SYSREQ];
    wdt_clr = wr && (ofs == `RSC_WDT_OFS) && avs_writedata_i[0];
    if (wr && (ofs == `RSC_CTRL_OFS))
    begin
      next_st.bor_en = avs_writedata_i[`RSC_CTL_BOREN];
      next_st.wdt_en = avs_writedata_i[`RSC_CTL_WDTEN];
    end
    if (wr && (ofs == `RSC_PSOFT_OFS))
      next_st.psoft = avs_writedata_i[7:0];
    if (wr && (ofs == `RSC_IMASK_OFS))
      next_st.imask = avs_writedata_i[1:0];

    // Detector is honoured once; a later blip cannot re-enter reset
    next_st.por_done = st.por_done || !por_det_i;
    por_live = !st.por_done;
    pin_low = !rst_pin_n_i;
    bor_rst = st.bor_en && brownout_i;
    pulse_src = sys_req || rq.wdt_rst;

    // Pulse sources get a fixed stretch; level sources hold directly
    if (pulse_src)
      next_st.hold = `RSC_HOLD_CYC;
    else if (st.hold != 4'h0)
      next_st.hold = st.hold - 4'h1;
    sys_rst = por_live || pin_low || bor_rst || pulse_src ||
              (st.hold != 4'h0);

    // Domain fan-out: test port follows power-on only
    next_st.core_rst = sys_rst;
    next_st.tap_rst = por_live;
    next_st.pcfg_rst = por_live || pin_low;
    next_st.prst = {8{sys_rst}} | rq.pactive;

    // Cause bits: set wins over clear, untouched by non power-on resets
    cause_set = {rq.wdt_rst, sys_req, bor_rst, pin_low, 1'b0} &
                {5{st.por_done}};
    if (wr && (ofs == `RSC_CAUSE_OFS))
      next_st.cause = st.cause & ~avs_writedata_i[4:0];
    next_st.cause = next_st.cause | cause_set;

    // Interrupts; a read clears only the bits it reported
    irq_set = 2'b00;
    irq_set[`RSC_I_BOR] = brownout_i && !st.bor_prev && !st.bor_en;
    irq_set[`RSC_I_WDT] = rq.wdt_flag && !st.wflag_prev;
    irq_clr = (rd && (ofs == `RSC_ISTS_OFS)) ? st.rdata[1:0] : 2'b00;
    next_st.ists = (st.ists & ~irq_clr) | irq_set;
    next_st.irq = |(next_st.ists & next_st.imask);
    next_st.bor_prev = brownout_i;
    next_st.wflag_prev = rq.wdt_flag;

    // Boot fetch order once the core leaves reset
    unique case (st.boot)
      BOOT_HOLD:
        if (!st.core_rst)
          next_st.boot = BOOT_SP;
      BOOT_SP:
        if (fetch_ack_i)
          next_st.boot = BOOT_PC;
      BOOT_PC:
        if (fetch_ack_i)
          next_st.boot = BOOT_INSN;
      BOOT_INSN:
        if (fetch_ack_i)
          next_st.boot = BOOT_RUN;
      BOOT_RUN:
        next_st.boot = BOOT_RUN;
      default:
        next_st.boot = BOOT_HOLD;
    endcase
    if (sys_rst)
      next_st.boot = BOOT_HOLD;
    next_st.freq = (next_st.boot == BOOT_SP) ||
                   (next_st.boot == BOOT_PC) ||
                   (next_st.boot == BOOT_INSN);
    next_st.fstep = next_st.freq ? (next_st.boot[1:0] - 2'h1) : 2'h0;
    next_st.run = (next_st.boot == BOOT_RUN);
  end

  // Only a true power-on clears this state
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st <= ST_RST;
    else
      st <= next_st;
  end

  // ==================================================================
  // Outputs
  assign avs_readdata_o = st.rdata;
  assign avs_waitrequest_o = st.wreq;
  assign irq_o = st.irq;
  assign core_rst_n_o = !st.core_rst;
  assign tap_rst_n_o = !st.tap_rst;
  assign pin_cfg_rst_n_o = !st.pcfg_rst;
  assign periph_rst_n_o = ~st.prst;
  assign fetch_req_o = st.freq;
  assign fetch_step_o = st.fstep;
  assign core_run_o = st.run;

  // ==================================================================
  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  pin_hold_a: assert property (
    !rst_pin_n_i |=> !core_rst_n_o && !pin_cfg_rst_n_o &&
    (periph_rst_n_o == 8'h00))
    else $error("pin low did not hold reset");
  tap_spared_a: assert property (
    st.por_done |=> tap_rst_n_o)
    else $error("test port reset outside power-on");
  por_wait_a: assert property (
    !st.por_done |=> !core_rst_n_o && !tap_rst_n_o)
    else $error("released before power-on detector went idle");
  por_once_a: assert property (
    st.por_done |=> st.por_done)
    else $error("power-on detector re-armed");
  bor_reset_a: assert property (
    brownout_i && st.bor_en |=> !core_rst_n_o && tap_rst_n_o)
    else $error("enabled brown-out did not reset core");
  bor_irq_a: assert property (
    $rose(brownout_i) && !st.bor_en && !st.bor_prev |=>
    st.ists[`RSC_I_BOR])
    else $error("disabled brown-out did not flag interrupt");
  sw_hold_a: assert property (
    sys_req && st.por_done |=> (!core_rst_n_o && tap_rst_n_o)[*5])
    else $error("software reset stretch wrong");
  cause_pin_a: assert property (
    !rst_pin_n_i && st.por_done |=> st.cause[`RSC_C_EXT])
    else $error("pin cause not recorded");
  cause_keep_a: assert property (
    st.cause[`RSC_C_WDT] && !(wr && ofs == `RSC_CAUSE_OFS) |=>
    st.cause[`RSC_C_WDT])
    else $error("cause bit lost without clear");
  boot_order_a: assert property (
    st.boot == BOOT_SP && fetch_ack_i && !sys_rst |=>
    fetch_req_o && fetch_step_o == 2'h1)
    else $error("stack pointer fetch not followed by counter");

  sw_reset_c: cover property (sys_req ##1 !core_rst_n_o);
  wdt_reset_c: cover property (rq.wdt_rst ##1 st.cause[`RSC_C_WDT]);
  boot_run_c: cover property (!core_rst_n_o ##[1:40] core_run_o);
  bor_irq_c: cover property (irq_set[`RSC_I_BOR] ##1 irq_o);
endmodule

// File: logic/rsc_wdt_qual.sv
// Watchdog time-out qualifier: interrupt first, reset on the second
`timescale 1ns/1ps
module rsc_wdt_qual
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  rsc_req_if.wdt rq
);
  typedef struct packed {
    logic flag;
    logic rst;
  } rsc_wdt_s;
  rsc_wdt_s st;
  rsc_wdt_s next_st;

  // Set wins over software clear so no time-out is lost
  always_comb
  begin
    next_st = st;
    next_st.rst = rq.wdt_to && st.flag && rq.wdt_en;
    next_st.flag = (st.flag && !rq.wdt_clr) || rq.wdt_to;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign rq.wdt_flag = st.flag;
  assign rq.wdt_rst = st.rst;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  second_out_a: assert property (
    rq.wdt_to && st.flag && rq.wdt_en |=> rq.wdt_rst)
    else $error("second time-out gave no reset");
  first_out_a: assert property (
    rq.wdt_to && !st.flag |=> !rq.wdt_rst && rq.wdt_flag)
    else $error("first time-out handled wrongly");
endmodule

// File: test/rsc_board_model.sv
// Board reset circuit, supply monitor and core fetch responder model
`timescale 1ns/1ps
module rsc_board_model
(
  input wire logic clk_i,
  input wire logic fetch_req_i,
  output logic por_det_o,
  output logic rst_pin_n_o,
  output logic brownout_o,
  output logic fetch_ack_o
);
  int ack_wait = 0;
  int cnt = 0;

  // ==================================================================
  // Supply and pin levels
  // Detector live from time zero, drops once the ramp is complete
  initial
  begin
    por_det_o = 1'b1;
    rst_pin_n_o = 1'b1;
    brownout_o = 1'b0;
    fetch_ack_o = 1'b0;
    repeat (12) @(posedge clk_i);
    por_det_o <= 1'b0;
  end

  // Callers pass a count longer than the minimum pin low time
  task automatic press_pin(input int n);
    rst_pin_n_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    rst_pin_n_o <= 1'b1;
  endtask

  task automatic sag(input int n);
    brownout_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    brownout_o <= 1'b0;
  endtask

  // Late detector pulse, used to prove it is ignored after power-up
  task automatic por_glitch(input int n);
    por_det_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    por_det_o <= 1'b0;
  endtask

  // ==================================================================
  // Fetch responder
  // One-cycle acknowledge after ack_wait idle cycles: prompt or slow
  always @(posedge clk_i)
  begin
    if (fetch_ack_o)
      fetch_ack_o <= 1'b0;
    else if (fetch_req_i && cnt >= ack_wait)
    begin
      fetch_ack_o <= 1'b1;
      cnt <= 0;
    end
    else
      cnt <= fetch_req_i ? cnt + 1 : 0;
  end
endmodule

// File: test/rsc_reset_ctrl_bench.sv
// Self-checking bench for the reset source control block
`timescale 1ns/1ps
module rsc_reset_ctrl_bench;
  logic clk_i, rst_n_i, wdt_timeout_i, avs_read_i, avs_write_i;
  logic por_det_i, rst_pin_n_i, brownout_i, fetch_ack_i;
  logic [2:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, d;
  logic [3:0] avs_byteenable_i;
  logic avs_waitrequest_o, irq_o, core_rst_n_o, tap_rst_n_o;
  logic pin_cfg_rst_n_o, fetch_req_o, core_run_o;
  logic [7:0] periph_rst_n_o;
  logic [1:0] fetch_step_o;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  // ==================================================================
  // Design and far side
  rsc_reset_ctrl i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .por_det_i(por_det_i), .rst_pin_n_i(rst_pin_n_i),
    .brownout_i(brownout_i), .wdt_timeout_i(wdt_timeout_i),
    .fetch_ack_i(fetch_ack_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o),
    .core_rst_n_o(core_rst_n_o), .tap_rst_n_o(tap_rst_n_o),
    .pin_cfg_rst_n_o(pin_cfg_rst_n_o),
    .periph_rst_n_o(periph_rst_n_o), .fetch_req_o(fetch_req_o),
    .fetch_step_o(fetch_step_o), .core_run_o(core_run_o));
  rsc_board_model i_board (.clk_i(clk_i), .fetch_req_i(fetch_req_o),
    .por_det_o(por_det_i), .rst_pin_n_o(rst_pin_n_i),
    .brownout_o(brownout_i), .fetch_ack_o(fetch_ack_i));

  // ==================================================================
  // Clock and hang guard
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      fail_count++;
      conclude();
    end
  end

  // ==================================================================
  // Shared helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Extra edge after release keeps back-to-back calls off one time step
  task automatic bus(input logic wr, input logic [2:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    // Waits on waitrequest alone; only the bench timeout ends a hang
    do
      @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, d);
    check(d, exp);
  endtask

  // Collect the acknowledged fetch steps until the core runs
  task automatic boot_check;
    int n;
    logic [1:0] got[$];
    n = 0;
    while (core_run_o !== 1'b1 && n < 80)
    begin
      @(posedge clk_i);
      if (fetch_ack_i === 1'b1)
      begin
        got.push_back(fetch_step_o);
        check(fetch_req_o, 1'b1);
      end
      n++;
    end
    check(got.size(), 3);
    for (int i = 0; i < got.size(); i++)
      check(got[i], i);
    check(core_run_o, 1'b1);
    check(fetch_req_o, 1'b0);
  endtask

  // ==================================================================
  // Scenarios
  task automatic t_power_up;
    cyc(2);
    check(core_rst_n_o, 1'b0);
    check(tap_rst_n_o, 1'b0);
    check(pin_cfg_rst_n_o, 1'b0);
    check(periph_rst_n_o, 8'h00);
    boot_check();
    check(tap_rst_n_o, 1'b1);
    rd_chk(3'h0, 32'h01);
    rd_chk(3'h7, 32'h00);
    // Boot state run, power-on done, every domain released
    rd_chk(3'h6, 32'h42);
  endtask

  // Level source held past the pulse length, then released
  task automatic src_reset(input logic pin, input logic [31:0] cause);
    fork
      if (pin)
        i_board.press_pin(8);
      else
        i_board.sag(8);
      begin
        cyc(6);
        check(core_rst_n_o, 1'b0);
        check(tap_rst_n_o, 1'b1);
        check(pin_cfg_rst_n_o, !pin);
        check(periph_rst_n_o, 8'h00);
      end
    join
    boot_check();
    rd_chk(3'h0, cause);
  endtask

  task automatic t_brownout;
    bus(1'b1, 3'h4, 32'h1, d);
    i_board.sag(3);
    cyc(1);
    check(core_rst_n_o, 1'b1);
    check(irq_o, 1'b1);
    rd_chk(3'h3, 32'h1);
    cyc(1);
    check(irq_o, 1'b0);
    bus(1'b1, 3'h4, 32'h0, d);
    i_board.sag(3);
    cyc(2);
    check(irq_o, 1'b0);
    rd_chk(3'h3, 32'h1);
    bus(1'b1, 3'h1, 32'h1, d);
    src_reset(1'b0, 32'h07);
  endtask

  task automatic t_sw;
    bus(1'b1, 3'h1, 32'h3, d);
    cyc(1);
    check(core_rst_n_o, 1'b0);
    check(periph_rst_n_o, 8'h00);
    check(tap_rst_n_o, 1'b1);
    boot_check();
    rd_chk(3'h1, 32'h1);
    rd_chk(3'h0, 32'h0f);
  endtask

  task automatic t_periph;
    int n;
    n = 0;
    bus(1'b1, 3'h2, 32'h05, d);
    check(periph_rst_n_o, 8'hff);
    bus(1'b1, 3'h2, 32'h00, d);
    repeat (8)
    begin
      @(posedge clk_i);
      if (periph_rst_n_o === 8'hfa)
        n++;
    end
    check(n, 3);
    check(core_rst_n_o, 1'b1);
    // A write without the low byte lane must leave the selection alone
    avs_byteenable_i <= 4'he;
    bus(1'b1, 3'h2, 32'hff, d);
    avs_byteenable_i <= 4'hf;
    rd_chk(3'h2, 32'h00);
  endtask

  task automatic pulse_wdt;
    wdt_timeout_i <= 1'b1;
    @(posedge clk_i);
    wdt_timeout_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic t_wdt;
    i_board.ack_wait = 3;
    bus(1'b1, 3'h1, 32'h5, d);
    bus(1'b1, 3'h4, 32'h2, d);
    pulse_wdt();
    cyc(2);
    check(irq_o, 1'b1);
    check(core_rst_n_o, 1'b1);
    rd_chk(3'h5, 32'h1);
    rd_chk(3'h3, 32'h2);
    pulse_wdt();
    cyc(2);
    check(core_rst_n_o, 1'b0);
    check(tap_rst_n_o, 1'b1);
    boot_check();
    rd_chk(3'h0, 32'h1f);
    // Software clear of the pending first time-out
    bus(1'b1, 3'h5, 32'h1, d);
    rd_chk(3'h5, 32'h0);
  endtask

  task automatic t_por_again;
    bus(1'b1, 3'h0, 32'h1f, d);
    rd_chk(3'h0, 32'h00);
    fork
      i_board.por_glitch(4);
      begin
        cyc(3);
        check(core_rst_n_o, 1'b1);
        check(tap_rst_n_o, 1'b1);
      end
    join
    rst_n_i <= 1'b0;
    cyc(2);
    rst_n_i <= 1'b1;
    boot_check();
    rd_chk(3'h0, 32'h01);
  endtask

  // ==================================================================
  // Verdict
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence; byte lane enables stay all-on except for the write without the low lane in t_periph
  initial
  begin
    rst_n_i = 1'b0;
    wdt_timeout_i = 1'b0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 3'h0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hf;
    cyc(4);
    rst_n_i <= 1'b1;
    t_power_up();
    src_reset(1'b1, 32'h03);
    t_brownout();
    t_sw();
    t_periph();
    t_wdt();
    t_por_again();
    conclude();
  end
endmodule
